// ===== core/dual_button_reset_timer.sv
/*
  dual push-button reset timer: reset pulse after a long both-low hold,
  plus a deglitched both-low indicator.
  assumes a free-running ref_clk; outputs are open-drain style, so each
  is a drive-low enable plus its level; pull-ups are off chip.
*/
// Notes on behaviour
// - both low past qualify period gives one fixed-width low reset pulse.
// - either input high during qualification clears the timer to zero.
// - a new pulse needs a full uninterrupted both-low qualification.
// - indicator goes low after both inputs low past deglitch time.
// - indicator stays low while both inputs stay low.
// - indicator returns high after either input high past deglitch time.
// - holding both low after a pulse gives no further pulses.
// - release during the pulse neither clears timer nor shortens pulse.
// - after the pulse, rearm needs both inputs high past deglitch time.
// - input changes shorter than deglitch time leave indicator unchanged.
// - outputs do not depend on which input falls first.
// - manual inputs are active low; undriven reads high.
`timescale 1ns/1ps
`include "dual_button_reset_regs.svh"
module dual_button_reset_timer #(
  parameter logic [31:0] QUALIFY_CYCLES = `QUALIFY_CYCLES,
  parameter logic [31:0] PULSE_CYCLES = `PULSE_CYCLES,
  parameter logic [31:0] DEGLITCH_CYCLES = `DEGLITCH_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // manual inputs, active low
  input wire logic manual_input_a_n,
  input wire logic manual_input_b_n,
  // reset output, open drain
  output logic resetOut_n,
  output logic resetOutEn,
  // both-low indicator, open drain
  output logic both_low_indicator_n,
  output logic bothLowIndicatorEn
);

  dual_button_reset_pkg::button_pair_t rawPair;
  dual_button_reset_pkg::button_pair_t syncPair;
  dual_button_reset_pkg::qual_state_t state_reg;
  logic [`CNT_W-1:0] qualCnt_reg;
  logic [`CNT_W-1:0] pulseCnt_reg;
  logic [`CNT_W-1:0] dgCnt_reg;
  logic [`CNT_W-1:0] rearmCnt_reg;
  logic bothLow;
  logic bothHigh;
  logic indicatorLow_reg;
  logic resetLow_reg;
  logic inCount;
  logic inPulse;
  logic inRearm;
  logic qualDone;
  logic pulseLast;
  logic rearmDone;
  logic dgDisagree;
  logic dgFlip;

  // saturating increment, shared by all timers
  function automatic logic [`CNT_W-1:0] incSat(
    input logic [`CNT_W-1:0] v
  );
    incSat = (v == {`CNT_W{1'b1}}) ? v : v + 32'h1;
  endfunction

  // threshold test; 'longer than' is met on the edge after reaching it
  function automatic logic reached(
    input logic [`CNT_W-1:0] cnt,
    input logic [`CNT_W-1:0] limit
  );
    reached = (cnt >= limit);
  endfunction

  // state decode, shared by the timers and the output flop
  function automatic logic inState(
    input dual_button_reset_pkg::qual_state_t cur,
    input dual_button_reset_pkg::qual_state_t want
  );
    inState = (cur == want);
  endfunction

  assign rawPair.inputA = manual_input_a_n;
  assign rawPair.inputB = manual_input_b_n;

  input_sync u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawIn(rawPair),
    .syncOut(syncPair)
  );

  // symmetric terms, so arrival order cannot matter
  assign bothLow = !syncPair.inputA && !syncPair.inputB;
  assign bothHigh = syncPair.inputA && syncPair.inputB;

  // state decodes
  assign inCount = inState(state_reg, dual_button_reset_pkg::QUAL_COUNT);
  assign inPulse = inState(state_reg, dual_button_reset_pkg::QUAL_PULSE);
  assign inRearm = inState(state_reg, dual_button_reset_pkg::QUAL_REARM);

  // end-of-period strobes; qualDone and pulseLast shared by state machine and output flop
  assign qualDone = inCount && bothLow
                    && reached(qualCnt_reg, QUALIFY_CYCLES);
  assign pulseLast = inPulse
                     && reached(pulseCnt_reg, PULSE_CYCLES - 32'h1);
  assign rearmDone = inRearm
                     && reached(rearmCnt_reg, DEGLITCH_CYCLES);

  // deglitch compare, both directions alike
  assign dgDisagree = bothLow != indicatorLow_reg;
  assign dgFlip = dgDisagree
                  && reached(dgCnt_reg, DEGLITCH_CYCLES);

  // qualification state machine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dual_button_reset_pkg::QUAL_IDLE;
    end else begin
      case (state_reg)
        dual_button_reset_pkg::QUAL_IDLE: begin
          if (bothLow) begin
            state_reg <= dual_button_reset_pkg::QUAL_COUNT;
          end
        end
        dual_button_reset_pkg::QUAL_COUNT: begin
          if (!bothLow) begin
            state_reg <= dual_button_reset_pkg::QUAL_IDLE;
          end else if (qualDone) begin
            state_reg <= dual_button_reset_pkg::QUAL_PULSE;
          end
        end
        dual_button_reset_pkg::QUAL_PULSE: begin
          // inputs ignored here, pulse always runs full length
          if (pulseLast) begin
            state_reg <= dual_button_reset_pkg::QUAL_REARM;
          end
        end
        dual_button_reset_pkg::QUAL_REARM: begin
          // held buttons park here, so no second pulse
          if (rearmDone) begin
            state_reg <= dual_button_reset_pkg::QUAL_IDLE;
          end
        end
        default: begin
          state_reg <= dual_button_reset_pkg::QUAL_IDLE;
        end
      endcase
    end
  end

  // qualification timer, from zero on each both-low run
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      qualCnt_reg <= 32'h0;
    end else if (inCount && bothLow) begin
      qualCnt_reg <= incSat(qualCnt_reg);
    end else if (!inPulse) begin
      qualCnt_reg <= 32'h0;
    end
  end

  // pulse width timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulseCnt_reg <= 32'h0;
    end else if (inPulse) begin
      pulseCnt_reg <= incSat(pulseCnt_reg);
    end else begin
      pulseCnt_reg <= 32'h0;
    end
  end

  // rearm timer, needs both released without a break
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rearmCnt_reg <= 32'h0;
    end else if (inRearm && bothHigh) begin
      rearmCnt_reg <= incSat(rearmCnt_reg);
    end else begin
      rearmCnt_reg <= 32'h0;
    end
  end

  // reset output flop
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetLow_reg <= 1'b0;
    end else begin
      // derived from state each edge, so no stale level can linger
      resetLow_reg <= qualDone || (inPulse && !pulseLast);
    end
  end

  // deglitch: count while input disagrees with indicator state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dgCnt_reg <= 32'h0;
    end else if (dgFlip) begin
      // restart on a flip, else a bounce right after it would pass
      dgCnt_reg <= 32'h0;
    end else if (dgDisagree) begin
      dgCnt_reg <= incSat(dgCnt_reg);
    end else begin
      dgCnt_reg <= 32'h0;
    end
  end

  // indicator flips only after a disagreement outlasts the deglitch time
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      indicatorLow_reg <= 1'b0;
    end else if (dgFlip) begin
      indicatorLow_reg <= bothLow;
    end
  end

  // open drain: level low only while driving
  assign resetOut_n = !resetLow_reg;
  assign resetOutEn = resetLow_reg;
  assign both_low_indicator_n = !indicatorLow_reg;
  assign bothLowIndicatorEn = indicatorLow_reg;

endmodule

// ===== inc/dual_button_reset_regs.svh
/*
  timing constants for the dual push-button reset timer.
  assumes a 40 MHz ref_clk; times are typical figures.
*/
`ifndef DUAL_BUTTON_RESET_REGS_SVH
`define DUAL_BUTTON_RESET_REGS_SVH

`define CLK_HZ 40000000
`define DEGLITCH_TIME_US 1500
`define QUALIFY_PERIOD_MS 6000
`define PULSE_WIDTH_PERIOD_MS 500
// least times scale straight to whole cycles, with nothing added for rounding
`define DEGLITCH_CYCLES \
  ((`DEGLITCH_TIME_US * (`CLK_HZ / 1000000) + 0) )
`define QUALIFY_CYCLES (`QUALIFY_PERIOD_MS * (`CLK_HZ / 1000))
`define PULSE_CYCLES (`PULSE_WIDTH_PERIOD_MS * (`CLK_HZ / 1000))
`define CNT_W 32

`endif

// ===== inc/dual_button_reset_pkg.sv
/*
  types for the dual push-button reset timer.
  assumes nothing beyond the constants header.
*/
package dual_button_reset_pkg;

  typedef enum logic [1:0] {
    QUAL_IDLE  = 2'b00,
    QUAL_COUNT = 2'b01,
    QUAL_PULSE = 2'b10,
    QUAL_REARM = 2'b11
  } qual_state_t;

  typedef struct packed {
    logic inputA;
    logic inputB;
  } button_pair_t;

endpackage

// ===== core/input_sync.sv
/*
  two-flop synchroniser for the two manual inputs.
  assumes inputs are asynchronous button levels, idle high.
*/
`timescale 1ns/1ps
module input_sync (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // raw and synchronised buttons
  input wire dual_button_reset_pkg::button_pair_t rawIn,
  output dual_button_reset_pkg::button_pair_t syncOut
);

  dual_button_reset_pkg::button_pair_t stage1_reg;
  dual_button_reset_pkg::button_pair_t stage2_reg;

  // reset to released, the idle level of a pulled-up input
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_reg <= 2'h3;
      stage2_reg <= 2'h3;
    end else begin
      stage1_reg <= rawIn;
      stage2_reg <= stage1_reg;
    end
  end

  assign syncOut = stage2_reg;

endmodule

// ===== dv/dual_button_reset_timer_asserts.sv
/* port checker for the reset timer, bound to its top module.
   assumes the short counts 40, 10 and 5 set by the bench. */
`timescale 1ns/1ps
module dual_button_reset_timer_asserts #(
  parameter logic [31:0] QUALIFY_CYCLES = 32'h28,
  parameter logic [31:0] PULSE_CYCLES = 32'ha,
  parameter logic [31:0] DEGLITCH_CYCLES = 32'h5
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // buttons
  input wire logic manual_input_a_n,
  input wire logic manual_input_b_n,
  // outputs
  input wire logic resetOut_n,
  input wire logic resetOutEn,
  input wire logic both_low_indicator_n,
  input wire logic bothLowIndicatorEn
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire bothLow = !manual_input_a_n && !manual_input_b_n;
  wire anyHigh = manual_input_a_n || manual_input_b_n;
  pulse_width_a: assert property ($fell(resetOut_n) |->
    (!resetOut_n)[*5] ##1 (!resetOut_n)[*5] ##1 resetOut_n)
    else $error("reset pulse width wrong");
  reset_drive_a: assert property (resetOutEn == !resetOut_n)
    else $error("reset enable disagrees with level");
  ind_drive_a: assert property (
    bothLowIndicatorEn == !both_low_indicator_n)
    else $error("indicator enable disagrees with level");
  full_qualify_a: assert property ($fell(resetOut_n) |->
    $past(bothLow, 3) && $past(bothLow, 23) && $past(bothLow, 43))
    else $error("reset pulse without full qualification");
  one_pulse_a: assert property ($rose(resetOut_n) |-> resetOut_n[*8])
    else $error("second reset pulse too soon");
  ind_set_a: assert property (bothLow[*8] ##1 bothLow[*4] |->
    !both_low_indicator_n)
    else $error("indicator not low after long press");
  ind_hold_a: assert property (
    !both_low_indicator_n && $past(bothLow, 2) |=> !both_low_indicator_n)
    else $error("indicator dropped while held");
  ind_clear_a: assert property (anyHigh[*8] ##1 anyHigh[*4] |->
    both_low_indicator_n)
    else $error("indicator not high after long release");
  ind_glitch_a: assert property ($fell(both_low_indicator_n) |->
    !$past(anyHigh, 3) && !$past(anyHigh, 6))
    else $error("indicator followed a short press");
  cover property ($fell(resetOut_n));
  cover property ($fell(both_low_indicator_n));
  cover property ($rose(both_low_indicator_n));
endmodule
bind dual_button_reset_timer dual_button_reset_timer_asserts #(
  .QUALIFY_CYCLES(QUALIFY_CYCLES), .PULSE_CYCLES(PULSE_CYCLES),
  .DEGLITCH_CYCLES(DEGLITCH_CYCLES)) chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .manual_input_a_n(manual_input_a_n),
  .manual_input_b_n(manual_input_b_n), .resetOut_n(resetOut_n),
  .resetOutEn(resetOutEn), .both_low_indicator_n(both_low_indicator_n),
  .bothLowIndicatorEn(bothLowIndicatorEn));

// ===== dv/button_pair_model.sv
/* two push-buttons on the manual inputs.
   assumes off-chip pull-ups: a released button reads high. */
`timescale 1ns/1ps
module button_pair_model (
  // press commands, a set bit holds that button down
  input wire dual_button_reset_pkg::button_pair_t pressCmd,
  // button pins
  output logic manual_input_a_n,
  output logic manual_input_b_n
);
  // released pin is pulled high, never left floating
  assign manual_input_a_n = pressCmd.inputA ? 1'b0 : 1'b1;
  assign manual_input_b_n = pressCmd.inputB ? 1'b0 : 1'b1;
endmodule

// ===== dv/dual_button_reset_timer_test.sv
/* self-checking bench for the reset timer with button model.
   assumes short counts: qualify 40, pulse 10, deglitch 5. */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
  err_total++; $display("[FAIL] %s exp %0h got %0h", what, exp, got); end end
module dual_button_reset_timer_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  dual_button_reset_pkg::button_pair_t pressCmd = 2'h0;
  logic pinA, pinB, rstOut_n, rstEn, ind_n, indEn;
  int err_total = 0;
  int checked = 0;
  int n;
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  button_pair_model btn (.pressCmd(pressCmd), .manual_input_a_n(pinA),
    .manual_input_b_n(pinB));
  dual_button_reset_timer #(.QUALIFY_CYCLES(32'h28), .PULSE_CYCLES(32'ha),
    .DEGLITCH_CYCLES(32'h5)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .manual_input_a_n(pinA), .manual_input_b_n(pinB), .resetOut_n(rstOut_n),
    .resetOutEn(rstEn), .both_low_indicator_n(ind_n),
    .bothLowIndicatorEn(indEn));
  // drive at an edge, return just after the last edge so outputs settle
  task automatic hold(input logic [1:0] cmd, input int cyc);
    @(posedge ref_clk);
    pressCmd <= cmd;
    repeat (cyc - 1) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitLow(input int limit, output int cnt);
    cnt = 0;
    while (rstOut_n !== 1'b0 && cnt < limit) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask
  task automatic glitchTest();
    hold(2'h3, 3);
    hold(2'h0, 12);
    `CHK("short press indicator", 1'b1, ind_n)
  endtask
  task automatic qualifyTest();
    hold(2'h1, 3);
    hold(2'h3, 12);
    `CHK("b first indicator", 1'b0, ind_n)
    `CHK("indicator enable", 1'b1, indEn)
    hold(2'h1, 3);
    hold(2'h3, 3);
    `CHK("short release indicator", 1'b0, ind_n)
    waitLow(100, n);
    `CHK("restart qualify", 1'b1, n >= 40 && n <= 48)
    `CHK("reset enable", 1'b1, rstEn)
    n = 1;
    while (rstOut_n === 1'b0 && n < 50) begin
      @(posedge ref_clk);
      if (n == 3) pressCmd <= 2'h0;
      #1;
      n++;
    end
    `CHK("pulse width", 10, n - 1)
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK("release indicator", 1'b1, ind_n)
  endtask
  task automatic rearmTest();
    hold(2'h0, 8);
    hold(2'h2, 2);
    hold(2'h3, 1);
    waitLow(100, n);
    `CHK("a first qualify", 1'b1, n >= 40 && n <= 48)
    repeat (12) @(posedge ref_clk);
    #1;
    waitLow(80, n);
    `CHK("one pulse only", 80, n)
    `CHK("held indicator", 1'b0, ind_n)
    // short release after the pulse must not rearm
    hold(2'h0, 3);
    hold(2'h3, 1);
    waitLow(60, n);
    `CHK("no rearm", 60, n)
  endtask
  task automatic results();
    if (err_total == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(25 * 2000);
    err_total++;
    results();
  end
  initial begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    glitchTest();
    qualifyTest();
    rearmTest();
    results();
  end
endmodule
